/* File: common/dcspi_if.sv */
// four-wire daisy-chain link plus reset line between controller and target
`timescale 1ns/1ns
interface dcspi_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo;
  logic dev_rst_n;

  modport host (
    output sclk,
    output cs_n,
    output sdi,
    output dev_rst_n,
    input  sdo
  );

  modport dev (
    input  sclk,
    input  cs_n,
    input  sdi,
    input  dev_rst_n,
    output sdo
  );
endinterface

/* File: common/dcspi_pkg.sv */
// constants shared by both ends of the daisy-chain serial register port
package dcspi_pkg;

  // core clock
  localparam int unsigned CLK_NS         = 20;

  // frame layout
  localparam int unsigned FRAME_BITS     = 16;
  localparam int unsigned CHAIN_LEN      = 3;
  localparam int unsigned CHAIN_BITS     = FRAME_BITS * CHAIN_LEN;
  localparam int unsigned ADDR_MSB       = 15;
  localparam int unsigned ADDR_LSB       = 9;
  localparam int unsigned RW_BIT         = 8;
  localparam int unsigned DATA_MSB       = 7;
  localparam int unsigned REG_COUNT      = 128;
  localparam logic [4:0]  CNT_FULL       = 5'h10;

  // values
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [7:0]  RET_DUMMY      = 8'h00;
  localparam logic [7:0]  REQ_DUMMY      = 8'hff;
  localparam logic [15:0] NOP_WORD       = 16'hffff;
  localparam logic [15:0] IDLE_LOAD      = 16'h0000;

  // reset timing
  localparam int unsigned RST_PULSE_NS   = 2500;
  localparam int unsigned RST_PULSE_CYC  = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WAKE_NS        = 1500000;
  localparam int unsigned WAKE_CYC       = WAKE_NS / CLK_NS;
  localparam int unsigned TMR_W          = 17;

  // host link pacing, in core cycles
  localparam int unsigned HALF_CYC       = 4;
  localparam int unsigned GAP_CYC        = 8;

endpackage

/* File: hw/dcspi_dev.sv */
// target end: link shift path on the serial clock, register file on the core clock
`timescale 1ns/1ns

// Functional notes
// - ignore clock and data while select high
// - output driven low while select high
// - sample input on rising serial clock
// - select rise hands frame to registers
// - output changes after falling serial clock
// - sixteen-bit pass-through per chained device
// - no decoding while select is low
// - msb first: address, read bit, data
// - controller starts from idle, clock low
// - clock low before select rises
// - short frame discarded, registers unchanged
// - read request: address, one, ones
// - return frame: dummy byte, then data
// - read needs two select periods
// - return frame may carry new request
// - reset clears registers and state
// - operational within two ms
// - reset low at least 2.5 us
// - ready within 1.5 ms of release
module dcspi_dev
  import dcspi_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_CYC
) (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  // link
  dcspi_if.dev            link,
  // register observation
  input  wire logic [6:0] rd_addr_i,
  output logic      [7:0] rd_data_o,
  output logic            wr_pulse_o,
  output logic            ready_o
);

  typedef struct packed {
    logic [15:0] shreg;
    logic [4:0]  cnt;
    logic        seen_id;
  } dcspi_lnk_s;

  typedef struct packed {
    logic        end_tgl;
    logic        done_tgl;
    logic [15:0] frame;
  } dcspi_cse_s;

  typedef struct packed {
    logic        out_bit;
    logic        started;
  } dcspi_neg_s;

  typedef struct packed {
    logic [1:0]                 sync;
    logic                       seen;
    logic [REG_COUNT-1:0][7:0]  regs;
    logic                       rd_pend;
    logic [7:0]                 rd_byte;
    logic [7:0]                 rd_data;
    logic                       wr_pulse;
    logic [TMR_W-1:0]           wait_cnt;
    logic                       ready;
  } dcspi_core_s;

  dcspi_lnk_s  lnk_q, lnk_d;
  dcspi_cse_s  cse_q, cse_d;
  dcspi_neg_s  neg_q, neg_d;
  dcspi_core_s core_q, core_d;

  logic [15:0] load_word;
  logic        evt;
  logic [6:0]  fr_addr;

  // read data prepared by the core; held stable while select is low
  assign load_word = core_q.rd_pend ? {RET_DUMMY, core_q.rd_byte} : IDLE_LOAD;

  // serial clock rising edge
  always_comb begin
    lnk_d = lnk_q;
    if (!link.cs_n) begin
      if (lnk_q.seen_id != cse_q.end_tgl) begin
        lnk_d.seen_id = cse_q.end_tgl;
        lnk_d.shreg   = {load_word[14:0], link.sdi};
        lnk_d.cnt     = 5'h01;
      end else begin
        lnk_d.shreg = {lnk_q.shreg[14:0], link.sdi};
        if (lnk_q.cnt != CNT_FULL) begin
          lnk_d.cnt = lnk_q.cnt + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge link.sclk or negedge nrst_i) begin
    if (!nrst_i) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  // serial clock falling edge; select high clears it
  always_comb begin
    neg_d         = neg_q;
    neg_d.out_bit = lnk_q.shreg[15];
    neg_d.started = 1'b1;
  end

  always_ff @(negedge link.sclk or negedge nrst_i or posedge link.cs_n) begin
    if (!nrst_i) begin
      neg_q <= '0;
    end else if (link.cs_n) begin
      neg_q <= '0;
    end else begin
      neg_q <= neg_d;
    end
  end

  // preload msb is always zero, so low before the first falling edge is correct
  // low while deselected
  assign link.sdo = ~link.cs_n & neg_q.started & neg_q.out_bit;

  // select rising edge
  always_comb begin
    cse_d = cse_q;
    // clockless frame keeps the toggle, so a stale count cannot alias
    if (lnk_q.seen_id == cse_q.end_tgl) begin
      cse_d.end_tgl = ~cse_q.end_tgl;
      if (lnk_q.cnt == CNT_FULL) begin
        cse_d.frame    = lnk_q.shreg;
        cse_d.done_tgl = ~cse_q.done_tgl;
      end
    end
  end

  always_ff @(posedge link.cs_n or negedge nrst_i) begin
    if (!nrst_i) begin
      cse_q <= '0;
    end else begin
      cse_q <= cse_d;
    end
  end

  // core domain
  assign evt     = core_q.sync[1] != core_q.seen;
  assign fr_addr = cse_q.frame[ADDR_MSB:ADDR_LSB];

  always_comb begin
    core_d          = core_q;
    core_d.wr_pulse = 1'b0;
    core_d.sync     = {core_q.sync[0], cse_q.done_tgl};
    core_d.seen     = core_q.sync[1];
    core_d.rd_data  = core_q.regs[rd_addr_i];
    if (!core_q.ready) begin
      if (core_q.wait_cnt == TMR_W'(WAKE_CYCLES)) begin
        core_d.ready = 1'b1;
      end else begin
        core_d.wait_cnt = core_q.wait_cnt + 1'b1;
      end
    end
    // frame stays put in cse_q until the next full frame ends
    if (evt && core_q.ready) begin
      if (cse_q.frame[RW_BIT]) begin
        core_d.rd_pend = 1'b1;
        core_d.rd_byte = core_q.regs[fr_addr];
      end else begin
        core_d.rd_pend         = 1'b0;
        core_d.regs[fr_addr]   = cse_q.frame[DATA_MSB:0];
        core_d.wr_pulse        = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      core_q <= '0;
    end else begin
      core_q <= core_d;
    end
  end

  assign rd_data_o  = core_q.rd_data;
  assign wr_pulse_o = core_q.wr_pulse;
  assign ready_o    = core_q.ready;

endmodule

/* File: hw/dcspi_host.sv */
// controller end: makes the serial clock by division and runs whole chain frames
`timescale 1ns/1ns
module dcspi_host
  import dcspi_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_CYC
) (
  // clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  nrst_i,
  // link
  dcspi_if.host                      link,
  // request
  input  wire logic                  req_valid_i,
  input  wire logic [CHAIN_BITS-1:0] req_data_i,
  output logic                       req_ready_o,
  // response
  output logic                       rsp_valid_o,
  output logic      [CHAIN_BITS-1:0] rsp_data_o
);

  typedef enum logic [2:0] {
    H_RST, H_WAKE, H_IDLE, H_LEAD, H_HIGH, H_LOW, H_TAIL, H_GAP
  } dcspi_hst_e;

  typedef struct packed {
    dcspi_hst_e            st;
    logic [TMR_W-1:0]      tmr;
    logic [5:0]            idx;
    logic [CHAIN_BITS-1:0] tx;
    logic [CHAIN_BITS-1:0] rx;
    logic [CHAIN_BITS-1:0] rsp;
    logic                  rsp_valid;
    logic                  sclk;
    logic                  cs_n;
    logic                  sdi;
    logic                  rst_n;
    logic [1:0]            sync;
  } dcspi_hst_s;

  dcspi_hst_s q, d;
  logic       tmr_done;

  assign tmr_done = q.tmr == '0;

  always_comb begin
    d           = q;
    d.rsp_valid = 1'b0;
    d.sync      = {q.sync[0], link.sdo};
    if (!tmr_done) begin
      d.tmr = q.tmr - 1'b1;
    end
    case (q.st)
      H_RST: begin
        if (tmr_done) begin
          d.rst_n = 1'b1;
          d.tmr   = TMR_W'(WAKE_CYCLES - 1);
          d.st    = H_WAKE;
        end
      end
      H_WAKE: begin
        if (tmr_done) begin
          d.st = H_IDLE;
        end
      end
      H_IDLE: begin
        if (req_valid_i) begin
          d.tx   = req_data_i;
          d.sdi  = req_data_i[CHAIN_BITS-1];
          d.cs_n = 1'b0;
          d.idx  = '0;
          d.tmr  = TMR_W'(HALF_CYC - 1);
          d.st   = H_LEAD;
        end
      end
      H_LEAD, H_LOW: begin
        if (tmr_done) begin
          d.sclk = 1'b1;
          d.rx   = {q.rx[CHAIN_BITS-2:0], q.sync[1]};
          d.tmr  = TMR_W'(HALF_CYC - 1);
          d.st   = H_HIGH;
        end
      end
      H_HIGH: begin
        if (tmr_done) begin
          d.sclk = 1'b0;
          d.tmr  = TMR_W'(HALF_CYC - 1);
          if (q.idx == 6'(CHAIN_BITS - 1)) begin
            d.st = H_TAIL;
          end else begin
            d.idx = q.idx + 6'h01;
            d.tx  = {q.tx[CHAIN_BITS-2:0], 1'b0};
            d.sdi = q.tx[CHAIN_BITS-2];
            d.st  = H_LOW;
          end
        end
      end
      H_TAIL: begin
        if (tmr_done) begin
          d.cs_n      = 1'b1;
          d.rsp       = q.rx;
          d.rsp_valid = 1'b1;
          d.tmr       = TMR_W'(GAP_CYC - 1);
          d.st        = H_GAP;
        end
      end
      default: begin
        // gap lets the target core absorb the frame
        if (tmr_done) begin
          d.st = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q       <= '0;
      q.st    <= H_RST;
      q.tmr   <= TMR_W'(RST_PULSE_CYC - 1);
      q.cs_n  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.sclk      = q.sclk;
  assign link.cs_n      = q.cs_n;
  assign link.sdi       = q.sdi;
  assign link.dev_rst_n = q.rst_n;
  assign req_ready_o    = q.st == H_IDLE;
  assign rsp_valid_o    = q.rsp_valid;
  assign rsp_data_o     = q.rsp;

endmodule

/* File: testbench/daisy_chain_spi_register_port_tb.sv */
// self-checking bench: host, three chained targets, one rule-breaking link
`timescale 1ns/1ns
module daisy_chain_spi_register_port_tb;
  import dcspi_pkg::*;
  localparam int unsigned WK = 20;
  logic                  core_clk_i;
  logic                  nrst_i;
  logic                  req_valid;
  logic [CHAIN_BITS-1:0] req_data;
  logic                  req_ready;
  logic                  rsp_valid;
  logic [CHAIN_BITS-1:0] rsp_data;
  logic [CHAIN_BITS-1:0] got;
  logic [6:0]            obs_addr;
  logic [7:0]            rdd [4];
  logic [3:0]            wrp;
  logic [3:0]            rdy;
  int                    error_cnt = 0;
  int                    samples_checked = 0;
  int                    cyc = 0;
  int                    wr_cnt [4];

  dcspi_if lh ();
  dcspi_if lk [3] ();
  dcspi_if lx ();

  assign lh.sdo        = lk[2].sdo;
  assign lk[0].sdi     = lh.sdi;
  assign lx.dev_rst_n  = nrst_i;

  dcspi_host #(.WAKE_CYCLES(WK)) i_dcspi_host (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .link(lh), .req_valid_i(req_valid), .req_data_i(req_data), .req_ready_o(req_ready),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data));

  for (genvar g = 0; g < 3; g++) begin : g_chain
    assign lk[g].sclk      = lh.sclk;
    assign lk[g].cs_n      = lh.cs_n;
    assign lk[g].dev_rst_n = lh.dev_rst_n;
    if (g > 0) begin : g_data
      assign lk[g].sdi = lk[g-1].sdo;
    end
    dcspi_dev #(.WAKE_CYCLES(WK)) i_dcspi_dev (.core_clk_i(core_clk_i), .nrst_i(lh.dev_rst_n),
      .link(lk[g]), .rd_addr_i(obs_addr), .rd_data_o(rdd[g]), .wr_pulse_o(wrp[g]),
      .ready_o(rdy[g]));
  end

  // lone target whose link the bench drives, short and unselected frames included
  if (1) begin : g_fault
    dcspi_dev #(.WAKE_CYCLES(WK)) i_dcspi_dev (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .link(lx), .rd_addr_i(obs_addr), .rd_data_o(rdd[3]), .wr_pulse_o(wrp[3]),
      .ready_o(rdy[3]));
  end

  dcspi_chk #(.WAKE_CYCLES(WK)) i_dcspi_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .sclk(lh.sclk), .cs_n(lh.cs_n), .sdi(lh.sdi), .sdo(lh.sdo), .dev_rst_n(lh.dev_rst_n));

  initial begin
    core_clk_i = 1'b0;
    forever #(CLK_NS/2) core_clk_i = ~core_clk_i;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // write pulses per target, counted where the pulse has settled
  always @(negedge core_clk_i) begin
    for (int g = 0; g < 4; g++) begin
      if (wrp[g] === 1'b1) begin
        wr_cnt[g]++;
      end
    end
  end

  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] act);
    samples_checked++;
    if (act !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, exp, act);
    end
  endtask

  function automatic logic [15:0] wf(input logic [6:0] a, input logic [7:0] d);
    return {a, 1'b0, d};
  endfunction

  function automatic logic [15:0] rf(input logic [6:0] a);
    return {a, 1'b1, REQ_DUMMY};
  endfunction

  // one whole chain transfer; request pulsed for one cycle once req_ready is seen
  task automatic xfer(input logic [47:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 1000) begin
      @(negedge core_clk_i);
      n++;
    end
    req_data  = d;
    req_valid = 1'b1;
    @(negedge core_clk_i);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 500) begin
      @(negedge core_clk_i);
      n++;
    end
    chk("rsp_valid", 48'h1, 48'(rsp_valid));
    got = rsp_data;
  endtask

  // a frame lands up to three cycles after select rises, read data one later
  task automatic peek(input logic [6:0] a, input logic [23:0] e, input logic [7:0] ex);
    @(negedge core_clk_i);
    obs_addr = a;
    repeat (6) @(negedge core_clk_i);
    chk("chain_regs", 48'(e), 48'({rdd[2], rdd[1], rdd[0]}));
    chk("lone_reg", 48'(ex), 48'(rdd[3]));
  endtask

  // 6 ns link clock, also toggled with select held high when hold is set; data line scrambled once released
  task automatic xframe(input int n, input logic [15:0] w, input logic hold);
    lx.cs_n = hold;
    for (int i = 15; i > 15 - n; i--) begin
      lx.sdi = w[i];
      #3 lx.sclk = 1'b1;
      #3 lx.sclk = 1'b0;
    end
    #3 lx.cs_n = 1'b1;
    lx.sdi = ~lx.sdi;
    #200;
  endtask

  initial begin
    nrst_i    = 1'b0;
    req_valid = 1'b0;
    req_data  = '0;
    obs_addr  = '0;
    lx.sclk   = 1'b0;
    lx.cs_n   = 1'b1;
    lx.sdi    = 1'b0;
    repeat (3) @(negedge core_clk_i);
    nrst_i = 1'b1;
    xfer({wf(7'h05, 8'ha5), wf(7'h05, 8'h3c), wf(7'h7e, 8'h81)});
    chk("first_out", 48'h0, got);
    peek(7'h05, 24'ha53c00, 8'h00);
    peek(7'h7e, 24'h000081, 8'h00);
    xfer({rf(7'h05), rf(7'h05), rf(7'h7e)});
    xfer({wf(7'h10, 8'h5a), rf(7'h05), wf(7'h05, 8'hc3)});
    chk("read_reply", 48'h00a5_003c_0081, got);
    xfer({3{NOP_WORD}});
    chk("overlap_reply", 48'h003c, 48'(got[31:16]));
    peek(7'h05, 24'ha53cc3, 8'h00);
    peek(7'h10, 24'h5a0000, 8'h00);
    xframe(16, wf(7'h05, 8'h77), 1'b0);
    xframe(0, 16'h0000, 1'b0);
    xframe(0, 16'h0000, 1'b0);
    peek(7'h05, 24'ha53cc3, 8'h77);
    xframe(15, wf(7'h05, 8'h11), 1'b0);
    peek(7'h05, 24'ha53cc3, 8'h77);
    xframe(16, wf(7'h05, 8'h22), 1'b1);
    chk("sdo_deselected", 48'h0, 48'(lx.sdo));
    peek(7'h05, 24'ha53cc3, 8'h77);
    nrst_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    nrst_i = 1'b1;
    chk("ready_early", 48'h0, 48'(rdy[3]));
    xframe(16, wf(7'h05, 8'h55), 1'b0);
    peek(7'h05, 24'h000000, 8'h00);
    while (rdy[3] !== 1'b1) @(negedge core_clk_i);
    xframe(16, wf(7'h05, 8'h66), 1'b0);
    xfer({wf(7'h05, 8'h01), wf(7'h05, 8'h02), wf(7'h05, 8'h03)});
    chk("reset_out", 48'h0, got);
    peek(7'h05, 24'h010203, 8'h66);
    chk("wr_cnt_dev0", 48'h3, 48'(wr_cnt[0]));
    chk("wr_cnt_dev1", 48'h2, 48'(wr_cnt[1]));
    chk("wr_cnt_dev2", 48'h3, 48'(wr_cnt[2]));
    chk("wr_cnt_lone", 48'h2, 48'(wr_cnt[3]));
    chk("chain_ready", 48'h7, 48'(rdy[2:0]));
    give_verdict();
  end
endmodule

/* File: testbench/dcspi_chk.sv */
// link checker: host pacing, target output and reset timing on the chain link
`timescale 1ns/1ns
module dcspi_chk
  import dcspi_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic dev_rst_n
);
  logic [5:0]       rise_q;
  logic [7:0]       low_q;
  logic [TMR_W-1:0] wake_q;

  // counts held in core cycles; link edges are host-registered
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rise_q <= '0;
      low_q  <= '0;
      wake_q <= '0;
    end else begin
      rise_q <= cs_n ? 6'h00 : rise_q + 6'($rose(sclk));
      low_q  <= dev_rst_n ? 8'h00 : low_q + 8'h01;
      wake_q <= !dev_rst_n ? '0 : wake_q + TMR_W'(wake_q != '1);
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  AST_SDO_LOW_IDLE: assert property (cs_n |-> !sdo)
    else $error("sdo not low while deselected");
  AST_SDO_ON_FALL: assert property (!cs_n && !$past(cs_n) && $changed(sdo) |-> $fell(sclk))
    else $error("sdo moved without a falling serial clock");
  AST_SCLK_FRAMED: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  AST_FRAME_LEN: assert property ($rose(cs_n) |-> rise_q == 6'(CHAIN_BITS) && !$past(sclk))
    else $error("frame closed with wrong clock count or clock high");
  AST_SDI_HOLD: assert property ($rose(sclk) |-> $stable(sdi) ##1 $stable(sdi))
    else $error("sdi moved around rising serial clock");
  AST_HALF_PERIOD: assert property ($rose(sclk) |=> $stable(sclk)[*3] ##1 $fell(sclk))
    else $error("serial clock high phase not four cycles");
  AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n[*5])
    else $error("select gap between frames too short");
  AST_RST_PULSE: assert property ($rose(dev_rst_n) |-> low_q >= 8'(RST_PULSE_CYC))
    else $error("target reset pulse too short");
  AST_WAKE_WAIT: assert property ($fell(cs_n) |-> wake_q >= TMR_W'(WAKE_CYCLES))
    else $error("frame started before wake time");
endmodule
